// >>> ccdhs_defines.svh
`ifndef CCDHS_DEFINES_SVH
`define CCDHS_DEFINES_SVH

// Register addresses
`define CCDHS_ADDR_TEST      8'h00
`define CCDHS_ADDR_SOFT_RST  8'h10
`define CCDHS_ADDR_OUT_EN    8'h11
`define CCDHS_ADDR_CORE_RST  8'h12
`define CCDHS_ADDR_HOLD      8'h14
`define CCDHS_ADDR_BLANK_CTL 8'h15
`define CCDHS_ADDR_OPTIONS   8'h16
`define CCDHS_ADDR_GAIN      8'h17
`define CCDHS_ADDR_CLAMP_LVL 8'h18
`define CCDHS_ADDR_LINE_STAT 8'h19
`define CCDHS_ADDR_SAMPLE    8'h63
// Address windows: toggle table at 1xxxxxxx, region table at 010xxxxx
`define CCDHS_TOG_WINDOW     1'h1
`define CCDHS_REGION_WINDOW  3'h2
`define CCDHS_SIG_COUNT      2'h3
`define CCDHS_CTRL_IDX       3'h6
`define CCDHS_SEL_BASE       1'h1

// Index into the general settings words
`define CCDHS_MISC_TEST      3'h0
`define CCDHS_MISC_OUT_EN    3'h1
`define CCDHS_MISC_BLANK     3'h2
`define CCDHS_MISC_OPT       3'h3
`define CCDHS_MISC_GAIN      3'h4
`define CCDHS_MISC_CLAMP     3'h5
`define CCDHS_MISC_SAMPLE    3'h6

// Signal numbers
`define CCDHS_SIG_CLAMP      2'h0
`define CCDHS_SIG_PBLANK     2'h1
`define CCDHS_SIG_HBLANK     2'h2

// Field positions
`define CCDHS_BLANK_SRC_BIT  0
`define CCDHS_BLANK_POL_BIT  1
`define CCDHS_BLANK_LVL_BIT  2
`define CCDHS_OPT_LOOP_OFF   2
`define CCDHS_CTRL_LEVEL_BIT 0
`define CCDHS_CTRL_EN_LSB    1

// Reset values and timing
`define CCDHS_CTRL_RST       12'h001
`define CCDHS_LINE_SYNC_DLY  3'h7

`endif

// >>> ccdhs_pkg.sv
package ccdhs_pkg;

    typedef logic [11:0] ccdhs_word_t;
    typedef logic [1:0]  ccdhs_seq_t;

    // Serial register request after deserialisation
    typedef struct packed {
        logic        write;
        logic [7:0]  addr;
        ccdhs_word_t data;
    } ccdhs_reg_req_t;

    // Settings handed to the analog chain
    typedef struct packed {
        logic [8:0] gain;
        logic [7:0] clamp_level;
        logic       clamp_loop_en;
        logic [5:0] sample_place;
        logic [7:0] test_field;
    } ccdhs_afe_ctrl_t;

    // One full register image: toggles, region table, general words
    typedef struct packed {
        ccdhs_word_t [2:0][3:0][6:0] tog;
        ccdhs_word_t [2:0][7:0]      region;
        ccdhs_word_t [7:0]           misc;
    } ccdhs_cfg_t;

    typedef enum logic [1:0] {
        CCDHS_LOC_NONE   = 2'h0,
        CCDHS_LOC_TOG    = 2'h1,
        CCDHS_LOC_REGION = 2'h2,
        CCDHS_LOC_MISC   = 2'h3
    } ccdhs_loc_kind_t;

    typedef struct packed {
        ccdhs_loc_kind_t kind;
        logic [1:0]      sig;
        logic [1:0]      seq;
        logic [2:0]      idx;
    } ccdhs_loc_t;

    typedef struct packed {
        ccdhs_cfg_t  pend;
        ccdhs_cfg_t  act;
        logic        core_run;
        logic        hold;
        logic        prev_line;
        logic        prev_frame;
        logic        armed;
        logic [2:0]  dly;
        ccdhs_word_t hcount;
        ccdhs_word_t line;
        logic        blank;
        logic        h1;
        ccdhs_word_t rdata;
    } ccdhs_state_t;

    typedef struct packed {
        logic level;
    } ccdhs_pulse_state_t;

endpackage : ccdhs_pkg

// >>> ccdhs_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none

module ccdhs_pulse_gen #(
    parameter int NUM_TOG = 2
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             clear,
    input  wire logic                             start_level,
    input  wire ccdhs_pkg::ccdhs_word_t           hcount,
    input  wire ccdhs_pkg::ccdhs_word_t [NUM_TOG-1:0] toggles,
    input  wire logic [NUM_TOG-1:0]               enables,
    output logic                                  level
);
    import ccdhs_pkg::*;

    ccdhs_pulse_state_t st;
    ccdhs_pulse_state_t next_st;
    logic               hit;

    // Any enabled toggle position matching the pixel count flips the level
    always_comb begin
        hit = 1'b0;
        for (int k = 0; k < NUM_TOG; k++) begin
            if (enables[k] && toggles[k] == hcount) begin
                hit = 1'b1;
            end
        end
        next_st = st;
        if (clear) begin
            next_st.level = start_level;
        end else if (hit) begin
            next_st.level = ~st.level;
        end
    end

    // Level register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;

endmodule : ccdhs_pulse_gen

`default_nettype wire

// >>> ccdhs_sequencer.sv
`include "ccdhs_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module ccdhs_sequencer #(
    parameter int TOG_PER_BLANK = 6,
    parameter int TOG_PER_PULSE = 2
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RESET,
    input  wire ccdhs_pkg::ccdhs_reg_req_t REG_REQ,
    output ccdhs_pkg::ccdhs_word_t         REG_RDATA,
    input  wire logic                      LINE_SYNC,
    input  wire logic                      FRAME_SYNC,
    input  wire logic                      EXT_BLANK,
    input  wire logic                      HCLK_PHASE,
    output logic                           FIRST_HCLK,
    output logic                           SECOND_HCLK,
    output logic                           BLACK_CLAMP_N,
    output logic                           PIXEL_BLANK_N,
    output logic                           HORIZONTAL_BLANK,
    output logic                           CLOCK_OUT_EN,
    output logic                           CLAMP_LOOP_STROBE,
    output ccdhs_pkg::ccdhs_afe_ctrl_t     AFE_CTRL
);
    import ccdhs_pkg::*;

    // Default image: clamp and pixel blank start inactive (high)
    function automatic ccdhs_state_t init_state();
        ccdhs_state_t s;
        s = '0;
        for (int g = 0; g < 2; g++) begin
            for (int q = 0; q < 4; q++) begin
                s.pend.tog[g][q][`CCDHS_CTRL_IDX] = `CCDHS_CTRL_RST;
            end
        end
        s.act = s.pend;
        return s;
    endfunction : init_state

    // Address to storage location; unknown addresses give LOC_NONE
    function automatic ccdhs_loc_t decode(input logic [7:0] a);
        ccdhs_loc_t l;
        l = '0;
        if (a[7] == `CCDHS_TOG_WINDOW) begin
            l.sig = a[6:5];
            l.seq = a[4:3];
            l.idx = a[2:0];
            if (l.sig < `CCDHS_SIG_COUNT && l.idx <= `CCDHS_CTRL_IDX) begin
                l.kind = CCDHS_LOC_TOG;
            end
        end else if (a[7:5] == `CCDHS_REGION_WINDOW) begin
            l.sig = a[4:3];
            l.idx = a[2:0];
            if (l.sig < `CCDHS_SIG_COUNT) begin
                l.kind = CCDHS_LOC_REGION;
            end
        end else begin
            l.kind = CCDHS_LOC_MISC;
            case (a)
                `CCDHS_ADDR_TEST:      l.idx = `CCDHS_MISC_TEST;
                `CCDHS_ADDR_OUT_EN:    l.idx = `CCDHS_MISC_OUT_EN;
                `CCDHS_ADDR_BLANK_CTL: l.idx = `CCDHS_MISC_BLANK;
                `CCDHS_ADDR_OPTIONS:   l.idx = `CCDHS_MISC_OPT;
                `CCDHS_ADDR_GAIN:      l.idx = `CCDHS_MISC_GAIN;
                `CCDHS_ADDR_CLAMP_LVL: l.idx = `CCDHS_MISC_CLAMP;
                `CCDHS_ADDR_SAMPLE:    l.idx = `CCDHS_MISC_SAMPLE;
                default:               l.kind = CCDHS_LOC_NONE;
            endcase
        end
        return l;
    endfunction : decode

    // Region from line count, then that region's sequence select
    function automatic ccdhs_seq_t sel_seq(input ccdhs_word_t [7:0] rt,
                                           input ccdhs_word_t       line);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 1; i < 4; i++) begin
            if (line >= rt[i]) begin
                r = 2'(i);
            end
        end
        return rt[{`CCDHS_SEL_BASE, r}][1:0];
    endfunction : sel_seq

    localparam ccdhs_state_t RST_STATE = init_state();

    ccdhs_state_t           st;
    ccdhs_state_t           next_st;
    ccdhs_loc_t             loc;
    logic                   line_fall;
    logic                   frame_fall;
    logic                   line_start;
    logic                   blank_now;
    logic                   blank_lvl;
    ccdhs_word_t            blank_ctl;
    ccdhs_seq_t  [2:0]      seq;
    ccdhs_word_t [2:0][6:0] act_tog;
    logic        [2:0]      lvl;

    always_comb begin
        for (int g = 0; g < 3; g++) begin
            seq[g]     = sel_seq(st.act.region[g], st.line);
            act_tog[g] = st.act.tog[g][seq[g]];
        end
    end

    // Pixel count restarts and sequence levels reload together
    assign line_start = ~st.core_run | (st.armed & (st.dly == 3'h0));

    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_pulse
        localparam int NT = (gi == 2) ? TOG_PER_BLANK : TOG_PER_PULSE;
        ccdhs_pulse_gen #(
            .NUM_TOG(NT)
        ) u_pulse (
            .clk        (CORE_CLK),
            .rst        (RESET),
            .clear      (line_start),
            .start_level((gi == 2) ? 1'b0 : act_tog[gi][6][`CCDHS_CTRL_LEVEL_BIT]),
            .hcount     (st.hcount),
            .toggles    (act_tog[gi][NT-1:0]),
            .enables    (act_tog[gi][6][NT:`CCDHS_CTRL_EN_LSB]),
            .level      (lvl[gi])
        );
    end

    assign blank_ctl = st.act.misc[`CCDHS_MISC_BLANK];

    // Blank source, polarity and first-clock mask level
    always_comb begin
        blank_now = lvl[`CCDHS_SIG_HBLANK];
        blank_lvl = act_tog[`CCDHS_SIG_HBLANK][6][`CCDHS_CTRL_LEVEL_BIT];
        if (blank_ctl[`CCDHS_BLANK_SRC_BIT]) begin
            blank_now = blank_ctl[`CCDHS_BLANK_POL_BIT] ? EXT_BLANK : ~EXT_BLANK;
            blank_lvl = blank_ctl[`CCDHS_BLANK_LVL_BIT];
        end
    end

    assign line_fall  = st.prev_line & ~LINE_SYNC;
    assign frame_fall = st.prev_frame & ~FRAME_SYNC;
    assign loc        = decode(REG_REQ.addr);

    // Next-state logic: register port, update transfer, counters, clocks
    always_comb begin
        next_st            = st;
        next_st.prev_line  = LINE_SYNC;
        next_st.prev_frame = FRAME_SYNC;

        // Table and general-word writes land in the pending image; core run and hold bits take effect at once
        if (REG_REQ.write) begin
            case (loc.kind)
                CCDHS_LOC_TOG: begin
                    next_st.pend.tog[loc.sig][loc.seq][loc.idx] = REG_REQ.data;
                end
                CCDHS_LOC_REGION: begin
                    // first region fixed at line zero
                    if (loc.idx != 3'h0) begin
                        next_st.pend.region[loc.sig][loc.idx] = REG_REQ.data;
                    end
                end
                CCDHS_LOC_MISC: begin
                    next_st.pend.misc[loc.idx] = REG_REQ.data;
                end
                default: begin
                    if (REG_REQ.addr == `CCDHS_ADDR_CORE_RST) begin
                        next_st.core_run = REG_REQ.data[0];
                    end
                    if (REG_REQ.addr == `CCDHS_ADDR_HOLD) begin
                        next_st.hold = REG_REQ.data[0];
                    end
                end
            endcase
        end

        // Read data registered one cycle after the address
        case (loc.kind)
            CCDHS_LOC_TOG: begin
                next_st.rdata = st.pend.tog[loc.sig][loc.seq][loc.idx];
            end
            CCDHS_LOC_REGION: begin
                next_st.rdata = st.pend.region[loc.sig][loc.idx];
            end
            CCDHS_LOC_MISC: begin
                next_st.rdata = st.pend.misc[loc.idx];
            end
            default: begin
                case (REG_REQ.addr)
                    `CCDHS_ADDR_CORE_RST:  next_st.rdata = ccdhs_word_t'(st.core_run);
                    `CCDHS_ADDR_HOLD:      next_st.rdata = ccdhs_word_t'(st.hold);
                    `CCDHS_ADDR_LINE_STAT: next_st.rdata = st.line;
                    default:               next_st.rdata = '0;
                endcase
            end
        endcase

        if ((line_fall | frame_fall) & ~st.hold) begin
            next_st.act = st.pend;
        end

        if (!st.core_run) begin
            next_st.hcount = '0;
            next_st.line   = '0;
            next_st.armed  = 1'b0;
            next_st.dly    = 3'h0;
        end else begin
            next_st.hcount = st.hcount + 12'h001;
            if (line_fall) begin
                next_st.armed = 1'b1;
                next_st.dly   = `CCDHS_LINE_SYNC_DLY - 3'h1;
            end else if (st.armed) begin
                if (st.dly == 3'h0) begin
                    next_st.hcount = '0;
                    next_st.armed  = 1'b0;
                end else begin
                    next_st.dly = st.dly - 3'h1;
                end
            end
            if (frame_fall) begin
                next_st.line = '0;
            end else if (line_fall) begin
                next_st.line = st.line + 12'h001;
            end
        end

        next_st.blank = blank_now;
        if (!st.act.misc[`CCDHS_MISC_OUT_EN][0]) begin
            next_st.h1 = 1'b0;
        end else if (blank_now) begin
            next_st.h1 = blank_lvl;
        end else begin
            next_st.h1 = HCLK_PHASE;
        end

        if (REG_REQ.write && REG_REQ.addr == `CCDHS_ADDR_SOFT_RST && REG_REQ.data[0]) begin
            next_st = RST_STATE;
        end
    end

    // State register; soft reset bit is never stored, so it reads zero
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign REG_RDATA        = st.rdata;
    assign FIRST_HCLK       = st.h1;
    assign SECOND_HCLK      = ~st.h1;
    assign BLACK_CLAMP_N    = lvl[`CCDHS_SIG_CLAMP];
    assign PIXEL_BLANK_N    = lvl[`CCDHS_SIG_PBLANK];
    assign HORIZONTAL_BLANK = st.blank;
    assign CLOCK_OUT_EN     = st.act.misc[`CCDHS_MISC_OUT_EN][0];

    always_comb begin
        AFE_CTRL.gain          = st.act.misc[`CCDHS_MISC_GAIN][8:0];
        AFE_CTRL.clamp_level   = st.act.misc[`CCDHS_MISC_CLAMP][7:0];
        AFE_CTRL.clamp_loop_en = ~st.act.misc[`CCDHS_MISC_OPT][`CCDHS_OPT_LOOP_OFF];
        AFE_CTRL.sample_place  = st.act.misc[`CCDHS_MISC_SAMPLE][5:0];
        AFE_CTRL.test_field    = st.act.misc[`CCDHS_MISC_TEST][7:0];
    end

    // compare window only while the clamp pulse is low
    assign CLAMP_LOOP_STROBE = ~lvl[`CCDHS_SIG_CLAMP] & AFE_CTRL.clamp_loop_en;

endmodule : ccdhs_sequencer

`default_nettype wire

// >>> ccdhs_sequencer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ccdhs_sequencer_chk (
    input wire logic                       CORE_CLK,
    input wire logic                       RESET,
    input wire ccdhs_pkg::ccdhs_reg_req_t  REG_REQ,
    input wire ccdhs_pkg::ccdhs_word_t     REG_RDATA,
    input wire logic                       HCLK_PHASE,
    input wire logic                       FIRST_HCLK,
    input wire logic                       SECOND_HCLK,
    input wire logic                       BLACK_CLAMP_N,
    input wire logic                       PIXEL_BLANK_N,
    input wire logic                       HORIZONTAL_BLANK,
    input wire logic                       CLOCK_OUT_EN,
    input wire logic                       CLAMP_LOOP_STROBE,
    input wire ccdhs_pkg::ccdhs_afe_ctrl_t AFE_CTRL
);
    import ccdhs_pkg::*;
    logic core_off;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    // Shadow of the core run bit, so parked stretches can be recognised
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            core_off <= 1'b1;
        end else if (REG_REQ.write && REG_REQ.addr == 8'h12) begin
            core_off <= ~REG_REQ.data[0];
        end else if (REG_REQ.write && REG_REQ.addr == 8'h10 && REG_REQ.data[0]) begin
            core_off <= 1'b1;
        end
    end
    a_second_clock_inverse: assert property (SECOND_HCLK == !FIRST_HCLK)
        else $error("second clock differs from inverse of first");
    a_disabled_clock_low: assert property (!CLOCK_OUT_EN [*2] |-> !FIRST_HCLK)
        else $error("first clock active while outputs disabled");
    a_strobe_from_clamp: assert property (!$past(RESET) |->
        CLAMP_LOOP_STROBE == (!BLACK_CLAMP_N && AFE_CTRL.clamp_loop_en))
        else $error("clamp loop strobe mismatch");
    a_clock_follows_phase: assert property ((CLOCK_OUT_EN && !HORIZONTAL_BLANK) [*2]
        |-> FIRST_HCLK == $past(HCLK_PHASE))
        else $error("first clock does not follow phase outside blank");
    a_blank_level_held: assert property ((CLOCK_OUT_EN && HORIZONTAL_BLANK) [*3]
        |-> $stable(FIRST_HCLK))
        else $error("first clock moved during blank");
    a_soft_reset_clears: assert property (
        REG_REQ.write && REG_REQ.addr == 8'h10 && REG_REQ.data[0]
        |=> !CLOCK_OUT_EN ##1 AFE_CTRL.gain == 9'h000)
        else $error("soft reset left settings behind");
    a_read_zero: assert property ((REG_REQ.addr == 8'h10 || REG_REQ.addr == 8'h3F)
        |=> REG_RDATA == 12'h000)
        else $error("trigger or unmapped address read nonzero");
    a_core_hold_levels: assert property (core_off [*4]
        |-> $stable(BLACK_CLAMP_N) && $stable(PIXEL_BLANK_N))
        else $error("pulse level moved while core held");
endmodule : ccdhs_sequencer_chk
bind ccdhs_sequencer ccdhs_sequencer_chk u_chk (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .HCLK_PHASE(HCLK_PHASE), .FIRST_HCLK(FIRST_HCLK), .SECOND_HCLK(SECOND_HCLK),
    .BLACK_CLAMP_N(BLACK_CLAMP_N), .PIXEL_BLANK_N(PIXEL_BLANK_N),
    .HORIZONTAL_BLANK(HORIZONTAL_BLANK), .CLOCK_OUT_EN(CLOCK_OUT_EN),
    .CLAMP_LOOP_STROBE(CLAMP_LOOP_STROBE), .AFE_CTRL(AFE_CTRL));
`default_nettype wire

// >>> ccdhs_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module ccdhs_sensor_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic kick_line,
    input  wire logic kick_frame,
    output logic      line_sync,
    output logic      frame_sync,
    output logic      hclk_phase
);
    logic [2:0] low_cnt;
    logic       with_frame;
    // Syncs present before programming; a request pulls them low four pixels
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            low_cnt <= 3'h0;
            with_frame <= 1'b0;
            hclk_phase <= 1'b0;
        end else begin
            hclk_phase <= ~hclk_phase;
            if (kick_line) begin
                low_cnt <= 3'h4;
                with_frame <= kick_frame;
            end else if (low_cnt != 3'h0) begin
                low_cnt <= low_cnt - 3'h1;
            end
        end
    end
    // Idle high syncs; frame fall only ever coincides with a line fall
    assign line_sync = (low_cnt == 3'h0);
    assign frame_sync = !(with_frame && low_cnt != 3'h0);
endmodule : ccdhs_sensor_model
`default_nettype wire

// >>> tb_ccd_horizontal_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ccd_horizontal_sequencer;
    import ccdhs_pkg::*;
    localparam int LINE_DLY = 7;
    logic            core_clk = 1'b0;
    logic            reset = 1'b1;
    ccdhs_reg_req_t  reg_req = '0;
    logic            ext_blank = 1'b0;
    logic            kick_line = 1'b0;
    logic            kick_frame = 1'b0;
    ccdhs_word_t     reg_rdata;
    logic            line_sync, frame_sync, hclk_phase, first_hclk, second_hclk;
    logic            clamp_n, pblank_n, hblank, out_en, loop_strobe;
    ccdhs_afe_ctrl_t afe_ctrl;
    int              n_errors = 0;
    int              tests_run = 0;
    logic            strobe_at_clamp;
    // Pixel clock, 25 ns period
    always #12.5 core_clk = ~core_clk;
    ccdhs_sequencer u_dut (.CORE_CLK(core_clk), .RESET(reset), .REG_REQ(reg_req),
        .REG_RDATA(reg_rdata), .LINE_SYNC(line_sync), .FRAME_SYNC(frame_sync),
        .EXT_BLANK(ext_blank), .HCLK_PHASE(hclk_phase), .FIRST_HCLK(first_hclk),
        .SECOND_HCLK(second_hclk), .BLACK_CLAMP_N(clamp_n), .PIXEL_BLANK_N(pblank_n),
        .HORIZONTAL_BLANK(hblank), .CLOCK_OUT_EN(out_en),
        .CLAMP_LOOP_STROBE(loop_strobe), .AFE_CTRL(afe_ctrl));
    ccdhs_sensor_model u_sensor (.clk(core_clk), .rst(reset), .kick_line(kick_line),
        .kick_frame(kick_frame), .line_sync(line_sync), .frame_sync(frame_sync),
        .hclk_phase(hclk_phase));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check
    task automatic final_report;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // One-cycle write strobe; the leading wait keeps calls from colliding
    task automatic wr(input logic [7:0] a, input ccdhs_word_t d);
        @(negedge core_clk);
        reg_req <= '{write: 1'b1, addr: a, data: d};
        @(negedge core_clk);
        reg_req.write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input ccdhs_word_t exp);
        @(negedge core_clk);
        reg_req <= '{write: 1'b0, addr: a, data: 12'h000};
        @(negedge core_clk);
        check(reg_rdata, exp);
    endtask : rd
    // One line: edges after the sync fall where clamp and blank move
    task automatic run_line(input logic fr, output int f, output int r, output int nb,
                            output logic h);
        logic hp;
        f = 0;
        r = 0;
        nb = 0;
        h = 1'bx;
        hp = 1'b0;
        strobe_at_clamp = 1'bx;
        @(negedge core_clk);
        kick_line <= 1'b1;
        kick_frame <= fr;
        @(negedge core_clk);
        kick_line <= 1'b0;
        kick_frame <= 1'b0;
        @(posedge core_clk);
        check(line_sync, 1'b0);
        // Long enough to see a clamp pulse of twenty pixels end
        for (int k = 1; k <= 40; k++) begin
            @(posedge core_clk);
            #1;
            if (clamp_n === 1'b0 && f == 0 && k > LINE_DLY) begin
                f = k;
                strobe_at_clamp = loop_strobe;
            end
            if (clamp_n === 1'b1 && f != 0 && r == 0) r = k;
            if (hblank === 1'b1 && hp) h = first_hclk;
            if (hblank === 1'b1 && !hp) nb++;
            hp = hblank;
        end
    endtask : run_line
    // Power-up order, held then released update
    task automatic sc_powerup;
        int f, r, n;
        logic h;
        wr(8'h10, 12'h001);
        wr(8'h12, 12'h000);
        wr(8'h12, 12'h001);
        wr(8'h14, 12'h001);
        wr(8'h17, 12'h1FF);
        wr(8'h63, 12'h02A);
        wr(8'h18, 12'h0FF);
        wr(8'h16, 12'h004);
        wr(8'h00, 12'h0C0);
        wr(8'h11, 12'h001);
        run_line(1'b0, f, r, n, h);
        check(out_en, 1'b0);
        check(afe_ctrl.gain, 9'h000);
        wr(8'h14, 12'h000);
        run_line(1'b0, f, r, n, h);
        check(out_en, 1'b1);
        check(afe_ctrl, {9'h1FF, 8'hFF, 1'b0, 6'h2A, 8'hC0});
    endtask : sc_powerup
    // Read back, refused places read zero
    task automatic sc_regs;
        logic [7:0]  ra [6] = '{8'h11, 8'h17, 8'h63, 8'h10, 8'h3F, 8'h40};
        ccdhs_word_t rv [6] = '{12'h001, 12'h1FF, 12'h02A, 12'h000, 12'h000, 12'h000};
        wr(8'h40, 12'h123);
        for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
    endtask : sc_regs
    // Clamp sequence chosen per line region
    task automatic sc_pulses;
        logic [7:0]  pa [12] = '{8'h80, 8'h81, 8'h86, 8'h88, 8'h89, 8'h8E,
                                 8'h41, 8'h42, 8'h43, 8'h45, 8'h16, 8'hA6};
        ccdhs_word_t pd [12] = '{12'h002, 12'h016, 12'h007, 12'h002, 12'h017, 12'h007,
                                 12'h001, 12'hFFF, 12'hFFF, 12'h001, 12'h000, 12'h000};
        int f, r, n;
        logic h;
        // Clamp pulses kept at least twenty pixels wide, pixel blank starts low
        for (int i = 0; i < 12; i++) wr(pa[i], pd[i]);
        for (int i = 0; i < 2; i++) begin
            run_line(i == 0, f, r, n, h);
            check(f, LINE_DLY + 1 + 2);
            check(r, LINE_DLY + 1 + ((i == 0) ? 22 : 23));
            check(strobe_at_clamp, 1'b1);
        end
        check(pblank_n, 1'b0);
        rd(8'h19, 12'h001);
    endtask : sc_pulses
    // Extra blank pulses from the spare toggles
    task automatic sc_blank;
        ccdhs_word_t cw [2] = '{12'h006, 12'h01F};
        int f, r, n;
        logic h;
        for (int i = 0; i < 4; i++) wr(8'hC0 + 8'(i), ccdhs_word_t'(3 * (i + 1)));
        // Mask level low on the first line, high on the second
        for (int i = 0; i < 2; i++) begin
            wr(8'hC6, cw[i]);
            run_line(1'b0, f, r, n, h);
            check(n, i + 1);
            check(h, i == 1);
        end
    endtask : sc_blank
    // External blank, both polarities and mask levels
    task automatic sc_ext;
        ccdhs_word_t ctl [4] = '{12'h003, 12'h003, 12'h005, 12'h005};
        logic        lvl [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        logic        eb [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic        eh [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
        int f, r, n;
        logic h;
        for (int i = 0; i < 4; i++) begin
            wr(8'h15, ctl[i]);
            ext_blank <= lvl[i];
            run_line(1'b0, f, r, n, h);
            check(hblank, eb[i]);
            if (eb[i]) check(first_hclk, eh[i]);
            if (eb[i]) check(second_hclk, !eh[i]);
        end
        wr(8'h15, 12'h000);
        ext_blank <= 1'b0;
    endtask : sc_ext
    // Soft reset parks the core at start level
    task automatic sc_reset;
        int f, r, n;
        logic h;
        wr(8'h10, 12'h001);
        rd(8'h17, 12'h000);
        rd(8'h12, 12'h000);
        run_line(1'b1, f, r, n, h);
        check(f, 0);
        check(clamp_n, 1'b1);
        check(pblank_n, 1'b1);
    endtask : sc_reset
    // Main sequence; every wait inside is a fixed, bounded loop
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        reset <= 1'b0;
        sc_powerup();
        sc_regs();
        sc_pulses();
        sc_blank();
        sc_ext();
        sc_reset();
        final_report();
    end
endmodule : tb_ccd_horizontal_sequencer
`default_nettype wire
